//--- rtl/csu_clock_source_unit.sv
// clock source unit: modes, reference and output dividers, debug clock
`timescale 1ns/1ps
`include "csu_cfg.svh"
// all ports stay on chip
module csu_clock_source_unit
    import csu_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       stop_req,
    input  wire logic       debug_active,
    output logic            system_clock_out,
    output logic            bus_clock,
    output logic            debug_port_clock,
    output logic            int_ref_clock_out,
    output logic            loop_enabled
);
    logic [7:0]     clock_control_one;
    logic [7:0]     clock_control_two;
    logic [8:0]     trim;
    logic [1:0]     clock_mode_status;
    logic [1:0]     status_sync;
    csu_mode_t      mode;
    csu_mode_t      next_mode;
    csu_src_t       src_eff;
    logic           prev_int_mode;
    logic           prev_ext_mode;
    logic [2:0]     stop_s;
    logic           stop_now;
    logic [15:0]    int_cnt;
    logic [15:0]    ext_cnt;
    logic           int_tick;
    logic           ext_tick;
    logic           loop_tick;
    logic [15:0]    loop_cnt;
    logic [5:0]     refdiv_cnt;
    logic           refdiv_tick;
    logic [5:0]     refdiv_top;
    logic [1:0]     cur_src;
    logic           sel_tick;
    logic           sys_phase;
    logic [2:0]     odiv_cnt;
    logic [2:0]     odiv_top;
    logic           dbg_phase;
    logic           int_run;
    logic           ext_run;

    // reserved source code acts as loop
    assign src_eff = (clock_control_one[`CSU_SRC_MSB:`CSU_SRC_LSB] == CSU_SRC_RSV) ?
                     CSU_SRC_LOOP :
                     csu_src_t'(clock_control_one[`CSU_SRC_MSB:`CSU_SRC_LSB]);

    // stop request from another domain: three flops, act when two agree
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stop_s <= 3'h0;
        end else begin
            stop_s <= {stop_s[1:0], stop_req};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stop_now <= 1'b0;
        end else if (stop_s[2] == stop_s[1]) begin
            stop_now <= stop_s[2];
        end
    end

    // register writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clock_control_one <= `CSU_CTRL1_RST;
            clock_control_two <= `CSU_CTRL2_RST;
            trim              <= `CSU_TRIM_RST;
        end else if (wr) begin
            unique case (addr)
                `CSU_ADDR_CTRL1: clock_control_one <= wdata;
                `CSU_ADDR_CTRL2: clock_control_two <= wdata;
                `CSU_ADDR_TRIM:  trim[8:1] <= wdata;
                `CSU_ADDR_STATUS: trim[0] <= wdata[0];
                default: ;
            endcase
        end
    end

    // register reads, data one cycle later
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                `CSU_ADDR_CTRL1: rdata <= clock_control_one | `CSU_CTRL1_FORCE1;
                `CSU_ADDR_CTRL2: rdata <= clock_control_two;
                `CSU_ADDR_TRIM:  rdata <= trim[8:1];
                `CSU_ADDR_STATUS: rdata <= {4'h0, clock_mode_status, 1'b0, trim[0]};
                default:         rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // mode from control fields
    always_comb begin
        next_mode = CSU_ENG_INT;
        if (stop_now) begin
            next_mode = CSU_STOP;
        end else begin
            unique case (src_eff)
                CSU_SRC_INT: next_mode = (clock_control_two[`CSU_LP_BIT] && !debug_active) ?
                                         CSU_BYP_INT_LP : CSU_BYP_INT;
                CSU_SRC_EXT: next_mode = (clock_control_two[`CSU_LP_BIT] && !debug_active) ?
                                         CSU_BYP_EXT_LP : CSU_BYP_EXT;
                default:     next_mode = clock_control_one[`CSU_REFSEL_BIT] ?
                                         CSU_ENG_INT : CSU_ENG_EXT;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode          <= CSU_ENG_INT;
            prev_int_mode <= 1'b1;
            prev_ext_mode <= 1'b0;
        end else begin
            mode <= next_mode;
            if (mode != CSU_STOP) begin
                prev_int_mode <= (mode == CSU_ENG_INT) || (mode == CSU_BYP_INT) ||
                                 (mode == CSU_BYP_INT_LP);
                prev_ext_mode <= (mode == CSU_ENG_EXT) || (mode == CSU_BYP_EXT) ||
                                 (mode == CSU_BYP_EXT_LP);
            end
        end
    end

    // reference run control in and out of stop
    always_comb begin
        int_run = 1'b1;
        ext_run = 1'b1;
        if (mode == CSU_STOP) begin
            int_run = clock_control_one[`CSU_IRSTEN_BIT] &&
                      (clock_control_one[`CSU_IREN_BIT] || prev_int_mode);
            ext_run = clock_control_two[`CSU_ERSTEN_BIT] && prev_ext_mode;
        end
    end

    // internal and external reference enables from prescalers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            int_cnt <= 16'h0000;
            ext_cnt <= 16'h0000;
            int_tick <= 1'b0;
            ext_tick <= 1'b0;
        end else begin
            int_tick <= int_run && (int_cnt == `CSU_INT_REF_DIV - 16'h0001);
            ext_tick <= ext_run && (ext_cnt == `CSU_EXT_REF_DIV - 16'h0001);
            int_cnt  <= (!int_run || int_cnt == `CSU_INT_REF_DIV - 16'h0001) ?
                        16'h0000 : int_cnt + 16'h0001;
            ext_cnt  <= (!ext_run || ext_cnt == `CSU_EXT_REF_DIV - 16'h0001) ?
                        16'h0000 : ext_cnt + 16'h0001;
        end
    end

    // reference divider on selected loop reference
    always_comb begin
        unique case (clock_control_one[`CSU_REFDIV_MSB:`CSU_REFDIV_LSB])
            3'h0:    refdiv_top = 6'h00;
            3'h1:    refdiv_top = 6'h01;
            3'h2:    refdiv_top = 6'h03;
            3'h3:    refdiv_top = 6'h07;
            3'h4:    refdiv_top = 6'h0f;
            default: refdiv_top = 6'h1f;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            refdiv_cnt  <= 6'h00;
            refdiv_tick <= 1'b0;
        end else begin
            refdiv_tick <= 1'b0;
            if (clock_control_one[`CSU_REFSEL_BIT] ? int_tick : ext_tick) begin
                if (refdiv_cnt >= refdiv_top) begin
                    refdiv_cnt  <= 6'h00;
                    refdiv_tick <= 1'b1;
                end else begin
                    refdiv_cnt <= refdiv_cnt + 6'h01;
                end
            end
        end
    end

    // loop oscillator model: runs only when loop is enabled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            loop_enabled <= 1'b1;
            loop_cnt     <= 16'h0000;
            loop_tick    <= 1'b0;
        end else begin
            loop_enabled <= !(next_mode == CSU_BYP_INT_LP || next_mode == CSU_BYP_EXT_LP ||
                              next_mode == CSU_STOP);
            loop_tick    <= loop_enabled && (loop_cnt == `CSU_LOOP_DIV - 16'h0001);
            loop_cnt     <= (!loop_enabled || loop_cnt == `CSU_LOOP_DIV - 16'h0001) ?
                            16'h0000 : loop_cnt + 16'h0001;
        end
    end

    // debug clock: loop divided by two
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dbg_phase        <= 1'b0;
            debug_port_clock <= 1'b0;
        end else if (!loop_enabled) begin
            dbg_phase        <= 1'b0;
            debug_port_clock <= 1'b0;
        end else if (loop_tick) begin
            dbg_phase <= !dbg_phase;
            if (dbg_phase) begin
                debug_port_clock <= !debug_port_clock;
            end
        end
    end

    // source switch only when system clock is low: no runt pulse
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur_src <= 2'h0;
        end else if (!system_clock_out) begin
            cur_src <= src_eff;
        end
    end

    always_comb begin
        unique case (cur_src)
            2'h1:    sel_tick = int_tick;
            2'h2:    sel_tick = ext_tick;
            default: sel_tick = loop_tick;
        endcase
    end

    // undivided system clock toggles on each selected tick
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sys_phase        <= 1'b0;
            system_clock_out <= 1'b0;
        end else if (mode == CSU_STOP) begin
            sys_phase        <= 1'b0;
            system_clock_out <= 1'b0;
        end else if (sel_tick) begin
            sys_phase        <= !sys_phase;
            system_clock_out <= !sys_phase;
        end
    end

    // output divider: bus is system clock over 2, 4, 8 or 16 by select
    always_comb begin
        unique case (clock_control_two[`CSU_ODIV_MSB:`CSU_ODIV_LSB])
            2'h0:    odiv_top = 3'h0;
            2'h1:    odiv_top = 3'h1;
            2'h2:    odiv_top = 3'h3;
            default: odiv_top = 3'h7;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            odiv_cnt  <= 3'h0;
            bus_clock <= 1'b0;
        end else if (mode == CSU_STOP) begin
            odiv_cnt  <= 3'h0;
            bus_clock <= 1'b0;
        end else if (sel_tick && !sys_phase) begin
            if (odiv_cnt >= odiv_top) begin
                odiv_cnt  <= 3'h0;
                bus_clock <= !bus_clock;
            end else begin
                odiv_cnt <= odiv_cnt + 3'h1;
            end
        end
    end

    // internal reference output gated by its enable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            int_ref_clock_out <= 1'b0;
        end else if (!clock_control_one[`CSU_IREN_BIT] || !int_run) begin
            int_ref_clock_out <= 1'b0;
        end else if (int_tick) begin
            int_ref_clock_out <= !int_ref_clock_out;
        end
    end

    // mode status passes two stages before showing
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_sync       <= 2'h0;
            clock_mode_status <= 2'h0;
        end else begin
            status_sync       <= cur_src;
            clock_mode_status <= status_sync;
        end
    end
endmodule : csu_clock_source_unit

//--- rtl/csu_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef CSU_CFG_SVH
`define CSU_CFG_SVH
`define CSU_ADDR_CTRL1     4'h0
`define CSU_ADDR_CTRL2     4'h1
`define CSU_ADDR_TRIM      4'h2
`define CSU_ADDR_STATUS    4'h3
`define CSU_SRC_MSB        7
`define CSU_SRC_LSB        6
`define CSU_REFDIV_MSB     5
`define CSU_REFDIV_LSB     3
`define CSU_REFSEL_BIT     2
`define CSU_IREN_BIT       1
`define CSU_IRSTEN_BIT     0
`define CSU_ODIV_MSB       7
`define CSU_ODIV_LSB       6
`define CSU_LP_BIT         3
`define CSU_ERSTEN_BIT     0
`define CSU_CTRL1_RST      8'h04
`define CSU_CTRL2_RST      8'h40
`define CSU_TRIM_RST       9'h100
`define CSU_CTRL1_FORCE1   8'h06
`define CSU_INT_REF_DIV    16'h0004
`define CSU_EXT_REF_DIV    16'h0002
`define CSU_LOOP_DIV       16'h0001
`define CSU_REF_MAX_KHZ    5000
`endif

//--- rtl/csu_pkg.sv
// types of the clock source unit
package csu_pkg;
    typedef enum logic [1:0] {
        CSU_SRC_LOOP = 2'h0,
        CSU_SRC_INT  = 2'h1,
        CSU_SRC_EXT  = 2'h2,
        CSU_SRC_RSV  = 2'h3
    } csu_src_t;
    typedef enum logic [6:0] {
        CSU_ENG_INT    = 7'h01,
        CSU_ENG_EXT    = 7'h02,
        CSU_BYP_INT    = 7'h04,
        CSU_BYP_INT_LP = 7'h08,
        CSU_BYP_EXT    = 7'h10,
        CSU_BYP_EXT_LP = 7'h20,
        CSU_STOP       = 7'h40
    } csu_mode_t;
endpackage : csu_pkg

//--- sim/csu_clock_source_unit_sva.sv
// port assertions for the clock source unit
`timescale 1ns/1ps
`include "csu_cfg.svh"
module csu_clock_source_unit_sva (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       stop_req,
    input wire logic       debug_active,
    input wire logic       system_clock_out,
    input wire logic       bus_clock,
    input wire logic       debug_port_clock,
    input wire logic       int_ref_clock_out,
    input wire logic       loop_enabled
);
    logic iren;
    // shadow of the internal reference enable bit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            iren <= 1'b0;
        end else if (wr && addr == `CSU_ADDR_CTRL1) begin
            iren <= wdata[`CSU_IREN_BIT];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_ctrl1_forced_ones: assert property (
        $past(rd) && $past(addr) == `CSU_ADDR_CTRL1 |-> rdata[2:1] == 2'b11)
        else $error("control one bits 2:1 not read as ones");
    chk_reset_loop_on: assert property (
        $rose(rstn) |-> loop_enabled && !system_clock_out)
        else $error("loop not engaged after reset");
    chk_stop_quiet: assert property (
        stop_req [*8] |-> !system_clock_out && !bus_clock && !debug_port_clock && !loop_enabled)
        else $error("clocks still running in stop");
    chk_debug_off: assert property (
        !loop_enabled [*3] |-> !debug_port_clock)
        else $error("debug clock present with loop off");
    chk_debug_runs: assert property (
        loop_enabled [*4] |-> ##[0:3] $changed(debug_port_clock))
        else $error("debug clock idle with loop on");
    chk_sys_runs: assert property (
        !stop_req [*8] |-> ##[0:9] $changed(system_clock_out))
        else $error("system clock idle outside stop");
    chk_iref_gated: assert property (
        !iren [*3] |-> !int_ref_clock_out)
        else $error("internal reference output active while disabled");
    chk_iref_runs: assert property (
        (iren && !stop_req) [*8] |-> ##[0:5] $changed(int_ref_clock_out))
        else $error("internal reference output idle while enabled");
endmodule : csu_clock_source_unit_sva

//--- sim/csu_clock_monitor.sv
// clock consumer model: measures a clock period in reference cycles, 0 when idle
`timescale 1ns/1ps
module csu_clock_monitor (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       clk_in,
    output logic      [7:0] period
);
    logic       last;
    logic [7:0] count;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            last   <= 1'b0;
            count  <= 8'h00;
            period <= 8'h00;
        end else begin
            last <= clk_in;
            if (clk_in && !last) begin
                period <= count + 8'h01;
                count  <= 8'h00;
            end else if (count == 8'h40) begin
                period <= 8'h00;
            end else begin
                count <= count + 8'h01;
            end
        end
    end
endmodule : csu_clock_monitor

//--- sim/csu_clock_source_unit_tb.sv
// self-checking bench for the clock source unit
`timescale 1ns/1ps
`include "csu_cfg.svh"
module csu_clock_source_unit_tb;
    logic       ref_clk;
    logic       rstn;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       stop_req;
    logic       debug_active;
    logic       system_clock_out;
    logic       bus_clock;
    logic       debug_port_clock;
    logic       int_ref_clock_out;
    logic       loop_enabled;
    logic [7:0] sys_per;
    logic [7:0] bus_per;
    logic [7:0] dbg_per;
    logic [7:0] irc_per;
    int         failures;
    int         checked;
    int         cycles;
    // ctrl1, ctrl2, debug, status, sys period, loop on, debug period
    localparam logic [7:0] mode_tab [6][7] = '{
        '{8'h44, 8'h40, 8'h00, 8'h04, 8'h08, 8'h01, 8'h04},
        '{8'h44, 8'h48, 8'h00, 8'h04, 8'h08, 8'h00, 8'h00},
        '{8'h44, 8'h48, 8'h01, 8'h04, 8'h08, 8'h01, 8'h04},
        '{8'h80, 8'h40, 8'h00, 8'h08, 8'h04, 8'h01, 8'h04},
        '{8'h80, 8'h48, 8'h00, 8'h08, 8'h04, 8'h00, 8'h00},
        '{8'hC4, 8'h40, 8'h00, 8'h00, 8'h02, 8'h01, 8'h04}};
    csu_clock_source_unit u_csu_clock_source_unit (.ref_clk(ref_clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_req(stop_req),
        .debug_active(debug_active), .system_clock_out(system_clock_out),
        .bus_clock(bus_clock), .debug_port_clock(debug_port_clock),
        .int_ref_clock_out(int_ref_clock_out), .loop_enabled(loop_enabled));
    csu_clock_monitor u_csu_clock_monitor_sys (.ref_clk(ref_clk), .rstn(rstn),
        .clk_in(system_clock_out), .period(sys_per));
    csu_clock_monitor u_csu_clock_monitor_bus (.ref_clk(ref_clk), .rstn(rstn),
        .clk_in(bus_clock), .period(bus_per));
    csu_clock_monitor u_csu_clock_monitor_dbg (.ref_clk(ref_clk), .rstn(rstn),
        .clk_in(debug_port_clock), .period(dbg_per));
    csu_clock_monitor u_csu_clock_monitor_irc (.ref_clk(ref_clk), .rstn(rstn),
        .clk_in(int_ref_clock_out), .period(irc_per));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : reg_rd
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        stop_req = 1'b0;
        debug_active = 1'b0;
        idle(12);
        rstn <= 1'b1;
        reg_rd(`CSU_ADDR_CTRL1, 8'h06);
        reg_rd(`CSU_ADDR_CTRL2, 8'h40);
        reg_rd(`CSU_ADDR_TRIM, 8'h80);
        reg_rd(`CSU_ADDR_STATUS, 8'h00);
        reg_rd(4'h9, 8'h00);
        for (int c = 0; c < 6; c++) begin
            reg_wr(`CSU_ADDR_CTRL1, {2'b00, c[2:0], 3'b100});
            reg_rd(`CSU_ADDR_CTRL1, {2'b00, c[2:0], 3'b110});
        end
        $display("test registers done");
        reg_wr(`CSU_ADDR_CTRL1, 8'h00);
        reg_rd(`CSU_ADDR_CTRL1, 8'h06);
        for (int d = 0; d < 4; d++) begin
            reg_wr(`CSU_ADDR_CTRL2, {d[1:0], 6'h00});
            idle(100);
            check(sys_per, 8'h02);
            check(dbg_per, 8'h04);
            check(bus_per, 8'(4 << d));
        end
        reg_wr(`CSU_ADDR_CTRL2, 8'h40);
        reg_wr(`CSU_ADDR_CTRL1, 8'h04);
        idle(80);
        check(sys_per, 8'h02);
        $display("test engaged modes done");
        for (int m = 0; m < 6; m++) begin
            debug_active <= mode_tab[m][2][0];
            reg_wr(`CSU_ADDR_CTRL2, mode_tab[m][1]);
            reg_wr(`CSU_ADDR_CTRL1, mode_tab[m][0]);
            idle(80);
            reg_rd(`CSU_ADDR_STATUS, mode_tab[m][3]);
            check(sys_per, mode_tab[m][4]);
            check({7'h00, loop_enabled}, mode_tab[m][5]);
            check(dbg_per, mode_tab[m][6]);
        end
        debug_active <= 1'b0;
        $display("test bypass modes done");
        reg_wr(`CSU_ADDR_CTRL1, 8'h07);
        idle(80);
        check(irc_per, 8'h08);
        stop_req <= 1'b1;
        idle(80);
        check(sys_per | bus_per | dbg_per, 8'h00);
        check({7'h00, loop_enabled}, 8'h00);
        check(irc_per, 8'h08);
        stop_req <= 1'b0;
        reg_wr(`CSU_ADDR_CTRL1, 8'h06);
        stop_req <= 1'b1;
        idle(80);
        check(irc_per, 8'h00);
        stop_req <= 1'b0;
        reg_wr(`CSU_ADDR_CTRL1, 8'h04);
        idle(80);
        check(irc_per, 8'h00);
        check(sys_per, 8'h02);
        $display("test stop done");
        complete_run();
    end
endmodule : csu_clock_source_unit_tb
bind csu_clock_source_unit csu_clock_source_unit_sva u_csu_clock_source_unit_sva (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_req(stop_req), .debug_active(debug_active),
    .system_clock_out(system_clock_out), .bus_clock(bus_clock),
    .debug_port_clock(debug_port_clock), .int_ref_clock_out(int_ref_clock_out),
    .loop_enabled(loop_enabled));
